//--- rtl/rpw_top.sv
// Power window timers, minute calibration strobe and alarm sequencer behind an APB slave.
// Assumes time counters outside supply the tick strobes and digit-equal flags in pclk domain.
//
// Summary of operation
// - Stability phase lasts stability_period_count power clock periods, up to 255.
// - Sampling follows stability; zero stability starts sampling at the alarm itself.
// - Sampling lasts sample_period_count periods; all-ones keeps sampling on always.
// - Writes to power_window_timer are dropped unless clock_write_enable is set.
// - Once a minute the signed calibration value times four is applied.
// - The final alarm of a sequence clears the alarm enable bit.
// - The four-bit digit mask picks which time digits must match.
// - Mask codes 0 to 9 select half second up to yearly intervals.
// - Zero repeat count without chime gives a single alarm.
// - Each alarm decrements the count; without chime the alarm at zero disables and stops.
// - Loading FFh gives up to 255 extra alarms.
// - With chime set the count wraps from zero to FFh indefinitely.
// - Every alarm event raises an interrupt request.
// - The alarm pulse output toggles on each alarm, synchronous to pclk.
// - The power control output polarity follows the polarity bit.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rpw_consts.svh"

module rpw_top
    import rpw_pkg::*;
#(
    parameter int CNT_W = 8 // Window counter width
) (
    input wire logic pclk, // APB clock, 50 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic half_sec_tick, // Pulse at each half second
    input wire logic sec_tick, // Pulse at each whole second
    input wire logic minute_tick, // Pulse once per minute
    input wire logic pwc_tick, // Pulse per power-control clock period
    input wire rpw_match_t digit_match, // Digit-equal flags
    output logic alarm_irq, // Alarm interrupt request pulse
    output logic alarm_pulse, // Toggles on each alarm
    output logic power_ctl_out, // External power switch drive
    output logic sample_window, // Wake-up sampling open
    output logic cal_strobe, // One-cycle adjust request
    output logic signed [9:0] cal_amount // Signed pulse count to apply
);
    logic [15:0] power_window_timer;
    logic unit_en;
    logic wren;
    logic signed [7:0] cal_value;
    rpw_alcfg_t alcfg;
    logic pwc_en;
    logic pwc_pol;
    rpw_pwc_state_t pwc_state;
    logic [CNT_W-1:0] win_cnt;
    logic sync_flag;

    logic wr_acc;
    logic rd_setup;
    logic addr_ok;
    logic [7:0] need;
    logic fire;
    logic alarm_evt;
    logic [CNT_W-1:0] stab_val;
    logic [CNT_W-1:0] samp_val;
    logic pwc_active;
    logic [31:0] next_rdata;

    assign stab_val = power_window_timer[`RPW_PWT_STAB_HI:`RPW_PWT_STAB_LO];
    assign samp_val = power_window_timer[`RPW_PWT_SAMP_HI:0];
    assign wr_acc = ce && psel && penable && pwrite && pready;
    assign rd_setup = psel && !penable;

    // Address decode; anything outside the map answers with an error
    always_comb begin
        unique case (paddr)
            `RPW_OFF_PWT, `RPW_OFF_CTRL, `RPW_OFF_CAL,
            `RPW_OFF_ALCFG, `RPW_OFF_PWC, `RPW_OFF_STAT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Read mux; reserved bits read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            `RPW_OFF_PWT: next_rdata[15:0] = power_window_timer;
            `RPW_OFF_CTRL: next_rdata[2:0] = {sync_flag, wren, unit_en};
            `RPW_OFF_CAL: next_rdata[7:0] = cal_value;
            `RPW_OFF_ALCFG: next_rdata[15:0] = alcfg;
            `RPW_OFF_PWC: next_rdata[15:14] = {pwc_en, pwc_pol};
            `RPW_OFF_STAT: next_rdata[11:0] = {alarm_pulse, sample_window, pwc_state,
                                                win_cnt};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // APB handshake: one wait-free access phase, answer registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= rd_setup;
            pslverr <= rd_setup && !addr_ok;
            if (rd_setup && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // Window timer register, guarded by the write-enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_window_timer <= `RPW_PWT_RST;
        end else if (wr_acc && paddr == `RPW_OFF_PWT && wren) begin
            power_window_timer <= pwdata[15:0];
        end
    end

    // Control, calibration and power-control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_en <= 1'b0;
            wren <= 1'b0;
            cal_value <= 8'sh00;
            pwc_en <= 1'b0;
            pwc_pol <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == `RPW_OFF_CTRL) begin
                unit_en <= pwdata[`RPW_CTRL_UNIT_EN];
                wren <= pwdata[`RPW_CTRL_WREN];
            end
            if (paddr == `RPW_OFF_CAL) begin
                cal_value <= pwdata[7:0];
            end
            if (paddr == `RPW_OFF_PWC) begin
                pwc_en <= pwdata[`RPW_PWC_EN];
                pwc_pol <= pwdata[`RPW_PWC_POL];
            end
        end
    end

    // Sync flag: high the cycle after a half-second, second or minute tick, so software can avoid the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_flag <= 1'b0;
        end else if (ce) begin
            sync_flag <= half_sec_tick || sec_tick || minute_tick;
        end
    end

    // Minute calibration: signed value scaled by four, sign kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_strobe <= 1'b0;
            cal_amount <= 10'sh000;
        end else if (ce) begin
            cal_strobe <= minute_tick && unit_en;
            if (minute_tick && unit_en) begin
                cal_amount <= {cal_value, 2'b00};
            end
        end
    end

    // Digits that must match for each mask code
    always_comb begin
        unique case (alcfg.mask)
            4'h0, 4'h1: need = 8'h00;
            4'h2: need = 8'h01;
            4'h3: need = 8'h03;
            4'h4: need = 8'h07;
            4'h5: need = 8'h0f;
            4'h6: need = 8'h1f;
            4'h7: need = 8'h3f;
            4'h8: need = 8'h5f;
            4'h9: need = 8'hdf;
            default: need = 8'hff;
        endcase
    end

    // Fire on the selected tick when every needed digit matches
    always_comb begin
        if (alcfg.mask == `RPW_MASK_HALF) begin
            fire = half_sec_tick;
        end else if (alcfg.mask > `RPW_MASK_YEAR) begin
            fire = 1'b0; // Unused codes never fire
        end else begin
            fire = sec_tick && ((digit_match & need) == need);
        end
    end
    assign alarm_evt = ce && unit_en && alcfg.en && fire;

    // Alarm config and repeat counter; the alarm event wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alcfg <= '0;
        end else if (alarm_evt) begin
            if (alcfg.rpt != `RPW_CNT_ZERO) begin
                alcfg.rpt <= alcfg.rpt - `RPW_CNT_ONE;
            end else if (alcfg.chime) begin
                alcfg.rpt <= `RPW_CNT_FULL;
            end else begin
                alcfg.en <= 1'b0;
            end
        end else if (wr_acc && paddr == `RPW_OFF_ALCFG) begin
            alcfg <= pwdata[15:0];
            alcfg.unused <= 2'b00;
        end
    end

    // Interrupt pulse and half-rate toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_irq <= 1'b0;
            alarm_pulse <= 1'b0;
        end else if (ce) begin
            alarm_irq <= alarm_evt;
            if (alarm_evt) begin
                alarm_pulse <= !alarm_pulse;
            end
        end
    end

    // Power-control sequencer; counts whole power-clock periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwc_state <= RPW_IDLE;
            win_cnt <= '0;
        end else if (ce) begin
            unique case (pwc_state)
                RPW_IDLE: begin
                    if (alarm_evt && pwc_en) begin
                        if (stab_val != '0) begin
                            pwc_state <= RPW_STAB;
                            win_cnt <= stab_val;
                        end else begin
                            pwc_state <= RPW_SAMP;
                            win_cnt <= samp_val;
                        end
                    end
                end
                RPW_STAB: begin
                    if (pwc_tick) begin
                        if (win_cnt == CNT_W'(1)) begin
                            pwc_state <= RPW_SAMP;
                            win_cnt <= samp_val;
                        end else begin
                            win_cnt <= win_cnt - CNT_W'(1);
                        end
                    end
                end
                RPW_SAMP: begin
                    if (win_cnt == '0 || !pwc_en) begin
                        pwc_state <= RPW_IDLE;
                    end else if (pwc_tick) begin
                        win_cnt <= win_cnt - CNT_W'(1);
                    end
                end
            endcase
        end
    end
    assign pwc_active = pwc_state != RPW_IDLE;

    // Registered pins; polarity bit set means active high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_ctl_out <= 1'b0;
            sample_window <= 1'b0;
        end else if (ce) begin
            power_ctl_out <= pwc_active ? pwc_pol : !pwc_pol;
            sample_window <= (pwc_state == RPW_SAMP && win_cnt != '0)
                             || samp_val == `RPW_CNT_FULL;
        end
    end

    // Checks
    property p_wren_guard;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == `RPW_OFF_PWT && !wren) |=> $stable(power_window_timer);
    endproperty
    a_wren_guard: assert property (p_wren_guard) else $error("window timer changed");

    property p_last_alarm;
        @(posedge pclk) disable iff (!presetn)
        (alarm_evt && alcfg.rpt == `RPW_CNT_ZERO && !alcfg.chime) |=> !alcfg.en;
    endproperty
    a_last_alarm: assert property (p_last_alarm) else $error("enable kept");

    property p_decrement;
        @(posedge pclk) disable iff (!presetn)
        (alarm_evt && alcfg.rpt != `RPW_CNT_ZERO) |=> alcfg.rpt == $past(alcfg.rpt) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement) else $error("no decrement");

    property p_chime_wrap;
        @(posedge pclk) disable iff (!presetn)
        (alarm_evt && alcfg.rpt == `RPW_CNT_ZERO && alcfg.chime)
            |=> alcfg.rpt == `RPW_CNT_FULL && alcfg.en;
    endproperty
    a_chime_wrap: assert property (p_chime_wrap) else $error("no wrap");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        alarm_evt |=> alarm_irq && (alarm_pulse != $past(alarm_pulse));
    endproperty
    a_irq: assert property (p_irq) else $error("alarm not signalled");

    property p_toggle_only;
        @(posedge pclk) disable iff (!presetn)
        (ce && !alarm_evt) |=> $stable(alarm_pulse);
    endproperty
    a_toggle_only: assert property (p_toggle_only) else $error("stray toggle");

    property p_cal;
        @(posedge pclk) disable iff (!presetn)
        (ce && minute_tick && unit_en) |=> cal_strobe && cal_amount == $past(cal_value) * 4;
    endproperty
    a_cal: assert property (p_cal) else $error("calibration wrong");

    property p_stab_to_samp;
        @(posedge pclk) disable iff (!presetn)
        (ce && pwc_state == RPW_STAB && pwc_tick && win_cnt == 8'h01)
            |=> pwc_state == RPW_SAMP && win_cnt == $past(samp_val);
    endproperty
    a_stab_to_samp: assert property (p_stab_to_samp) else $error("no sample start");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (pwc_state == RPW_IDLE && alarm_evt && pwc_en && stab_val != 8'h00)
            |=> pwc_state == RPW_STAB ##1 power_ctl_out == pwc_pol;
    endproperty
    a_start: assert property (p_start) else $error("sequence not started");

    property p_mask_half;
        @(posedge pclk) disable iff (!presetn)
        (ce && unit_en && alcfg.en && alcfg.mask == 4'h0 && half_sec_tick) |=> alarm_irq;
    endproperty
    a_mask_half: assert property (p_mask_half) else $error("half second missed");
endmodule

//--- rtl/rpw_consts.svh
// Register offsets, field positions, reset values and figures for the window/alarm block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef RPW_CONSTS_SVH
`define RPW_CONSTS_SVH

// Byte offsets on the APB (one 32-bit word each)
`define RPW_OFF_PWT 8'h00
`define RPW_OFF_CTRL 8'h04
`define RPW_OFF_CAL 8'h08
`define RPW_OFF_ALCFG 8'h0c
`define RPW_OFF_PWC 8'h10
`define RPW_OFF_STAT 8'h14

// Control register fields
`define RPW_CTRL_UNIT_EN 0
`define RPW_CTRL_WREN 1
`define RPW_CTRL_SYNC 2

// Alarm configuration fields
`define RPW_AL_EN 15
`define RPW_AL_CHIME 14
`define RPW_AL_MASK_HI 13
`define RPW_AL_MASK_LO 10
`define RPW_AL_RPT_HI 7

// Power control register fields
`define RPW_PWC_EN 15
`define RPW_PWC_POL 14

// Window timer fields
`define RPW_PWT_STAB_HI 15
`define RPW_PWT_STAB_LO 8
`define RPW_PWT_SAMP_HI 7

// Reset values and special codes
`define RPW_PWT_RST 16'h0000
`define RPW_CNT_ZERO 8'h00
`define RPW_CNT_FULL 8'hff
`define RPW_CNT_ONE 8'h01
`define RPW_MASK_HALF 4'h0
`define RPW_MASK_YEAR 4'h9

`endif

//--- rtl/rpw_pkg.sv
// Types shared by the window/alarm block.
// Assumes rpw_consts.svh sits beside it.
package rpw_pkg;
    `include "rpw_consts.svh"

    // Power-control sequence phase
    typedef enum logic [1:0] {
        RPW_IDLE,
        RPW_STAB,
        RPW_SAMP
    } rpw_pwc_state_t;

    // Digit-equal flags from the time counters
    typedef struct packed {
        logic month;
        logic day;
        logic wday;
        logic hour;
        logic min_ten;
        logic min_one;
        logic sec_ten;
        logic sec_one;
    } rpw_match_t;

    // Alarm configuration word
    typedef struct packed {
        logic en;
        logic chime;
        logic [3:0] mask;
        logic [1:0] unused;
        logic [7:0] rpt;
    } rpw_alcfg_t;
endpackage

//--- tb/rpw_ext_dev.sv
// External device model: a switched load that also acts as a wake-up source.
// Assumes the bench passes the chosen polarity, because the pin alone does not show it.
`timescale 1ns/1ps
module rpw_ext_dev (
    input wire logic pclk, // Bench clock
    input wire logic power_ctl_out, // Switch drive from the block
    input wire logic pol, // Active level of the switch
    input wire logic sample_window, // Sampling open
    output logic powered, // Device has supply
    output logic wake // Wake-up event seen by the bench, not by the block
);
    int on_cycles = 0;

    // Supply follows the switch at the chosen polarity
    assign powered = (power_ctl_out == pol);
    // Wake needs supply for at least one cycle; a cold part cannot signal
    assign wake = powered & sample_window & (on_cycles > 0);
    // Warm-up count, cleared whenever the supply drops
    always_ff @(posedge pclk) begin
        on_cycles <= powered ? on_cycles + 1 : 0;
    end
endmodule

//--- tb/rpw_top_tb_top.sv
// Self-checking bench for the window timer, calibration and alarm block.
// Assumes the ticks and digit flags come from the bench in place of the time counters.
`timescale 1ns/1ps
module rpw_top_tb_top;
    import rpw_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } rpw_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pol = 0, ce = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, alarm_irq, alarm_pulse, power_ctl_out, sample_window;
    logic cal_strobe, powered, wake, exp_pulse;
    logic signed [9:0] cal_amount;
    logic [3:0] tk = 4'h0;
    rpw_match_t dm = 8'hff;
    int err_count = 0, tests_run = 0, irq_cnt = 0, prev;
    // APB rows: write, address, data, expected read, expected error
    rpw_row_t rows [10] = '{
        {1'b1, 8'h04, 32'h3, 32'h0, 1'b0}, {1'b1, 8'h00, 32'h203, 32'h0, 1'b0},
        {1'b0, 8'h00, 32'h0, 32'h203, 1'b0}, {1'b1, 8'h04, 32'h1, 32'h0, 1'b0},
        {1'b1, 8'h00, 32'hffff, 32'h0, 1'b0}, {1'b0, 8'h00, 32'h0, 32'h203, 1'b0},
        {1'b1, 8'h08, 32'hfe, 32'h0, 1'b0}, {1'b0, 8'h08, 32'h0, 32'hfe, 1'b0},
        {1'b0, 8'h18, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h04, 32'h3, 32'h0, 1'b0}};

    // Half period of 10 ns gives 50 MHz
    always #10 pclk = ~pclk;

    rpw_top #(.CNT_W(8)) i_rpw_top (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .half_sec_tick(tk[0]),
        .sec_tick(tk[1]), .minute_tick(tk[2]), .pwc_tick(tk[3]), .digit_match(dm),
        .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse), .power_ctl_out(power_ctl_out),
        .sample_window(sample_window), .cal_strobe(cal_strobe), .cal_amount(cal_amount));
    rpw_ext_dev i_rpw_ext_dev (.pclk(pclk), .power_ctl_out(power_ctl_out), .pol(pol),
        .sample_window(sample_window), .powered(powered), .wake(wake));

    // Interrupt pulses last one cycle, so count them at every edge
    always @(posedge pclk) begin
        if (alarm_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task results();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; holds everything until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdck(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(rd, x);
    endtask

    // One-cycle tick; returns just after the edge that takes it
    task pulse(input int i);
        @(posedge pclk);
        tk[i] <= 1'b1;
        @(posedge pclk);
        tk[i] <= 1'b0;
        #1;
    endtask

    // Power-control clock ticks spaced so the phase changes can settle
    task pw(input int n);
        repeat (n) begin
            pulse(3);
            repeat (3) @(posedge pclk);
        end
        #1;
    endtask

    task al(input logic [31:0] cfg, input int t);
        apb(1'b1, 8'h0c, cfg);
        pulse(t);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        check({alarm_irq, alarm_pulse, power_ctl_out, sample_window, cal_strobe}, 0);
        presetn <= 1'b1;
        rdck(8'h0c, 32'h0);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check(rd, rows[i].x);
            check(er, rows[i].e);
        end
        pulse(2);
        check({cal_strobe, cal_amount}, {1'b1, 10'h3f8});
        // Each mask code 0 to 9 fires once on a full digit match, then disables
        exp_pulse = alarm_pulse;
        for (int m = 0; m < 10; m++) begin
            prev = irq_cnt;
            al(32'h8000 | (m << 10), (m == 0) ? 0 : 1);
            exp_pulse = ~exp_pulse;
            rdck(8'h0c, m << 10);
            check(irq_cnt, prev + 1);
            check(alarm_pulse, exp_pulse);
        end
        // Codes past nine and a missing minute digit must stay silent
        prev = irq_cnt;
        dm.min_ten <= 1'b0;
        al(32'h8000 | (10 << 10), 1);
        al(32'h8000 | (5 << 10), 1);
        rdck(8'h0c, 32'h9400);
        check(irq_cnt, prev);
        // Repeat count of two gives three alarms; mask one ignores minutes
        prev = irq_cnt;
        al(32'h8402, 1);
        rdck(8'h0c, 32'h8401);
        pulse(1);
        pulse(1);
        rdck(8'h0c, 32'h0400);
        check(irq_cnt, prev + 3);
        al(32'h84ff, 1);
        rdck(8'h0c, 32'h84fe);
        al(32'hc400, 1);
        rdck(8'h0c, 32'hc4ff);
        // Clock enable low swallows a tick; the chime alarm stays armed
        prev = irq_cnt;
        ce <= 1'b0;
        pulse(1);
        @(posedge pclk);
        ce <= 1'b1;
        rdck(8'h0c, 32'hc4ff);
        check(irq_cnt, prev);
        // Sequence with stability two, sample three, active high
        pol = 1'b1;
        apb(1'b1, 8'h10, 32'hc000);
        al(32'h8400, 1);
        repeat (3) @(posedge pclk);
        #1;
        check({power_ctl_out, powered}, 2'b11);
        pw(1);
        check(sample_window, 0);
        pw(1);
        check({sample_window, wake}, 2'b11);
        pw(2);
        check(sample_window, 1);
        pw(1);
        check({sample_window, power_ctl_out}, 2'b00);
        // Zero stability samples at once
        apb(1'b1, 8'h00, 32'h0001);
        al(32'h8400, 1);
        repeat (3) @(posedge pclk);
        #1;
        check(sample_window, 1);
        pw(2);
        apb(1'b1, 8'h10, 32'h8000);
        pol = 1'b0;
        // The pin follows the new polarity one edge after the write lands
        repeat (2) @(posedge pclk);
        #1;
        check({power_ctl_out, powered}, 2'b10);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h00, 32'h00ff);
        repeat (2) @(posedge pclk);
        #1;
        check(sample_window, 1);
        // Reset in mid-run returns pins and the window timer to zero
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check({sample_window, power_ctl_out, alarm_irq}, 0);
        rdck(8'h00, 32'h0);
        results();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        results();
    end
endmodule
